// [logic/psmc_pkg.sv]
package psmc_pkg;

    // ------------------------------------------------------------
    // Oscillator start-up delay, in CPU cycles
    // ------------------------------------------------------------
    localparam int STARTUP_SHORT_CYC = 256;
    localparam int STARTUP_LONG_CYC = 4096;
    localparam int DLY_W = 12;
    localparam logic [DLY_W-1:0] DLY_LOAD_SHORT = DLY_W'(STARTUP_SHORT_CYC - 1);
    localparam logic [DLY_W-1:0] DLY_LOAD_LONG = DLY_W'(STARTUP_LONG_CYC - 1);
    localparam logic [DLY_W-1:0] DLY_ZERO = 12'h000;

    // ------------------------------------------------------------
    // Slow-mode prescaler
    // ------------------------------------------------------------
    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] DIV_ONE = 4'h1;
    localparam logic [DIV_W-1:0] DIV_TWO = 4'h2;

    // ------------------------------------------------------------
    // Interrupt mask level
    // ------------------------------------------------------------
    localparam logic [1:0] MASK_ALL_ENABLED = 2'h2;
    localparam logic [1:0] MASK_RESET = 2'h3;

    // ------------------------------------------------------------
    // Reported power mode
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_RUN = 3'h0;
    localparam logic [2:0] MODE_SLOW = 3'h1;
    localparam logic [2:0] MODE_WAIT = 3'h2;
    localparam logic [2:0] MODE_SLOW_WAIT = 3'h3;
    localparam logic [2:0] MODE_ACTIVE_HALT = 3'h4;
    localparam logic [2:0] MODE_HALT = 3'h5;
    localparam logic [2:0] MODE_STARTUP = 3'h6;

    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_WAIT = 5'h02,
        ST_AHALT = 5'h04,
        ST_HALT = 5'h08,
        ST_START = 5'h10
    } psmc_state_t;

endpackage

// [logic/psmc_div_if.sv]
`timescale 1ns/10ps
interface psmc_div_if;
    logic slow;
    logic [1:0] prescale;
    logic tick;
    modport ctrl (output slow, output prescale, input tick);
    modport div (input slow, input prescale, output tick);
endinterface

// [logic/psmc_clkdiv.sv]
`timescale 1ns/10ps
module psmc_clkdiv (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    psmc_div_if.div dif
);
    import psmc_pkg::*;

    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic [DIV_W-1:0] last;

    // Divide by 2, 4, 8 or 16: the tick marks the last master cycle of each CPU cycle
    assign last = DIV_W'((DIV_TWO << dif.prescale) - DIV_ONE);
    assign dif.tick = !dif.slow || (cnt_r == last);
    assign cnt_nxt = (dif.tick || cnt_r > last) ? '0 : DIV_W'(cnt_r + DIV_ONE);

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (clk_en) begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

// [logic/psmc_ctrl.sv]
// Function
// R1: Reset enters run mode on master clock.
// R2: Slow mode divides CPU clock by 2..16.
// R3: Wait during slow mode keeps slow clock.
// R4: Wait stops CPU, peripherals keep running.
// R5: Wait forces interrupt mask level to 10.
// R6: Wait ends only on interrupt or reset.
// R7: Wake-up service pushes flags, sets priority.
// R8: Halt instruction picks halt or active-halt.
// R9: Active-halt runs only oscillator and timebase.
// R10: Interrupt leaves active-halt without start-up delay.
// R11: Reset leaves active-halt through start-up delay.
// R12: Halt entry forces mask; pending wakes at once.
// R13: Active-halt never triggers a watchdog reset.
// R14: Early timebase-enable clear falls back to halt. (Code stops osc and clocks until the background count ends; state stays run.)
// R15: Halt stops oscillator and all peripherals.
// R16: Halt exit waits 256 or 4096 cycles.
// R17: Watchdog option may turn halt into reset.
// R18: Timebase wakes active-halt only; external both.
`timescale 1ns/10ps
module psmc_ctrl (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic slow_select,
    input wire logic [1:0] cpu_prescale_bits,
    input wire logic timebase_irq_enable,
    input wire logic wait_for_irq_instr,
    input wire logic halt_instr,
    input wire logic watchdog_enabled,
    input wire logic watchdog_halt_option,
    input wire logic long_delay_option,
    input wire logic reset_event,
    input wire logic irq_pending,
    input wire logic [1:0] irq_priority,
    input wire logic ext_irq,
    input wire logic timebase_irq,
    input wire logic css_irq,
    input wire logic ccr_pop,
    input wire logic [1:0] ccr_pop_level,
    output logic [2:0] power_mode,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic timebase_clk_en,
    output logic osc_enable,
    output logic startup_busy,
    output logic [1:0] irq_mask_level,
    output logic irq_service,
    output logic stack_push_ccr,
    output logic reset_vector_fetch,
    output logic watchdog_reset_req
);
    import psmc_pkg::*;

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    psmc_div_if dif ();

    assign dif.slow = slow_select; // see R2
    assign dif.prescale = cpu_prescale_bits;

    psmc_clkdiv u_div (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .dif(dif)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    psmc_state_t state_r, state_nxt;
    logic [DLY_W-1:0] dly_r, dly_nxt;
    logic [DLY_W-1:0] bg_r, bg_nxt;
    logic bg_active_r, bg_active_nxt;
    logic wake_rst_r, wake_rst_nxt;
    logic [1:0] mask_r, mask_nxt;
    logic svc, rvf, wdr, dly_load, bg_load;
    logic tick;
    logic wake_ahalt, wake_halt, dly_done, bg_done;
    logic osc_off_r14, cpu_nxt, per_nxt, osc_nxt, forced;
    logic [DLY_W-1:0] dly_init;
    logic [2:0] mode_nxt;

    assign tick = dif.tick;
    assign wake_ahalt = ext_irq || timebase_irq || css_irq; // see R18
    assign wake_halt = ext_irq; // see R18
    assign dly_init = long_delay_option ? DLY_LOAD_LONG : DLY_LOAD_SHORT; // see R16
    assign dly_done = tick && (dly_r == DLY_ZERO);
    assign bg_done = tick && (bg_r == DLY_ZERO);

    // ------------------------------------------------------------
    // Mode sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        wake_rst_nxt = wake_rst_r;
        svc = 1'b0;
        rvf = 1'b0;
        wdr = 1'b0;
        dly_load = 1'b0;
        bg_load = 1'b0;
        unique case (state_r)
            ST_RUN: begin
                if (reset_event) begin
                    rvf = 1'b1;
                end else if (wait_for_irq_instr) begin
                    state_nxt = ST_WAIT; // see R3
                end else if (halt_instr) begin
                    if (timebase_irq_enable) begin
                        state_nxt = ST_AHALT; // see R8
                    end else if (watchdog_enabled && watchdog_halt_option) begin
                        wdr = 1'b1; // see R17
                    end else begin
                        state_nxt = ST_HALT; // see R8
                    end
                end
            end
            ST_WAIT: begin
                if (reset_event) begin
                    rvf = 1'b1; // see R6
                    state_nxt = ST_RUN;
                end else if (irq_pending) begin
                    svc = 1'b1; // see R6
                    state_nxt = ST_RUN;
                end
            end
            ST_AHALT: begin
                if (reset_event) begin
                    state_nxt = ST_START; // see R11
                    wake_rst_nxt = 1'b1;
                    dly_load = 1'b1;
                end else if (wake_ahalt) begin
                    svc = 1'b1; // see R10
                    bg_load = 1'b1;
                    state_nxt = ST_RUN;
                end
            end
            ST_HALT: begin
                if (reset_event || wake_halt) begin
                    state_nxt = ST_START; // see R16
                    wake_rst_nxt = reset_event;
                    dly_load = 1'b1;
                end
            end
            ST_START: begin
                if (dly_done) begin
                    state_nxt = ST_RUN; // see R16
                    svc = !wake_rst_r;
                    rvf = wake_rst_r;
                    wake_rst_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Start-up and background delay counters
    // ------------------------------------------------------------
    // The background count after an active-halt wake only matters if
    // software drops the timebase enable before it runs out
    assign dly_nxt = dly_load ? dly_init : (tick && dly_r != DLY_ZERO) ?
                     DLY_W'(dly_r - 1'b1) : dly_r;
    assign bg_nxt = bg_load ? dly_init : (tick && bg_r != DLY_ZERO) ?
                    DLY_W'(bg_r - 1'b1) : bg_r;
    assign bg_active_nxt = bg_load || (bg_active_r && !bg_done);

    // ------------------------------------------------------------
    // Clock gating and mask
    // ------------------------------------------------------------
    assign osc_off_r14 = bg_active_r && !timebase_irq_enable; // see R14
    assign osc_nxt = (state_nxt != ST_HALT) && !osc_off_r14; // see R15
    assign cpu_nxt = (state_nxt == ST_RUN) && !osc_off_r14 && tick; // see R4
    assign per_nxt = (state_nxt == ST_RUN || state_nxt == ST_WAIT) && !osc_off_r14 &&
                     tick; // see R9
    assign forced = (state_nxt == ST_WAIT) || (state_nxt == ST_AHALT) ||
                    (state_nxt == ST_HALT);
    assign mask_nxt = svc ? irq_priority : forced ? MASK_ALL_ENABLED : // see R7
                      ccr_pop ? ccr_pop_level : mask_r; // see R12
    assign mode_nxt = (state_nxt == ST_RUN) ? (slow_select ? MODE_SLOW : MODE_RUN) :
                      (state_nxt == ST_WAIT) ? (slow_select ? MODE_SLOW_WAIT : MODE_WAIT) :
                      (state_nxt == ST_AHALT) ? MODE_ACTIVE_HALT :
                      (state_nxt == ST_HALT) ? MODE_HALT : MODE_STARTUP;

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= ST_RUN; // see R1
            dly_r <= DLY_ZERO;
            bg_r <= DLY_ZERO;
            bg_active_r <= 1'b0;
            wake_rst_r <= 1'b0;
            mask_r <= MASK_RESET;
        end else if (clk_en) begin
            state_r <= state_nxt;
            dly_r <= dly_nxt;
            bg_r <= bg_nxt;
            bg_active_r <= bg_active_nxt;
            wake_rst_r <= wake_rst_nxt;
            mask_r <= mask_nxt; // see R5
        end
    end

    // Registered outputs, aligned with the state they describe
    always_ff @(posedge clock) begin
        if (rst) begin
            power_mode <= MODE_RUN;
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            timebase_clk_en <= 1'b0;
            osc_enable <= 1'b1;
            startup_busy <= 1'b0;
            irq_service <= 1'b0;
            stack_push_ccr <= 1'b0;
            reset_vector_fetch <= 1'b0;
            watchdog_reset_req <= 1'b0;
        end else if (clk_en) begin
            power_mode <= mode_nxt;
            cpu_clk_en <= cpu_nxt;
            periph_clk_en <= per_nxt;
            timebase_clk_en <= osc_nxt; // see R9
            osc_enable <= osc_nxt;
            startup_busy <= (state_nxt == ST_START);
            irq_service <= svc;
            stack_push_ccr <= svc; // see R7
            reset_vector_fetch <= rvf;
            watchdog_reset_req <= wdr; // see R13
        end
    end

    assign irq_mask_level = mask_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst || !clk_en);

    property p_reset_run;
        $past(rst) |-> power_mode == MODE_RUN && osc_enable && state_r == ST_RUN;
    endproperty
    a_reset_run: assert property (p_reset_run) else $error("not in run after reset"); // see R1

    property p_slow_div;
        state_r == ST_RUN && slow_select && cpu_prescale_bits == 2'h0 && cpu_clk_en &&
            !bg_active_r ##1 state_r == ST_RUN && $stable(slow_select) |-> !cpu_clk_en;
    endproperty
    a_slow_div: assert property (p_slow_div) else $error("slow clock not divided"); // see R2

    property p_wait_slow;
        state_r == ST_WAIT && slow_select |-> power_mode == MODE_SLOW_WAIT;
    endproperty
    a_wait_slow: assert property (p_wait_slow) else $error("slow-wait not shown"); // see R3

    property p_wait_cpu;
        state_r == ST_WAIT |-> !cpu_clk_en && osc_enable;
    endproperty
    a_wait_cpu: assert property (p_wait_cpu) else $error("cpu clocked in wait"); // see R4

    property p_forced_mask;
        state_r inside {ST_WAIT, ST_AHALT, ST_HALT} |-> irq_mask_level == MASK_ALL_ENABLED;
    endproperty
    a_forced_mask: assert property (p_forced_mask) else $error("mask not forced"); // see R5

    property p_wait_exit;
        state_r == ST_WAIT && !irq_pending && !reset_event |=> state_r == ST_WAIT;
    endproperty
    a_wait_exit: assert property (p_wait_exit) else $error("wait left without cause"); // see R6

    property p_service_push;
        irq_service |-> stack_push_ccr && irq_mask_level == $past(irq_priority);
    endproperty
    a_service_push: assert property (p_service_push) else $error("bad service"); // see R7

    property p_halt_pick;
        state_r == ST_RUN && !reset_event && !wait_for_irq_instr && halt_instr &&
            timebase_irq_enable |=> state_r == ST_AHALT;
    endproperty
    a_halt_pick: assert property (p_halt_pick) else $error("active-halt not entered"); // see R8

    property p_ahalt_irq;
        state_r == ST_AHALT && !reset_event && timebase_irq |=>
            irq_service && state_r == ST_RUN && !startup_busy;
    endproperty
    a_ahalt_irq: assert property (p_ahalt_irq) else $error("active-halt wake delayed"); // see R10

    property p_ahalt_rst;
        state_r == ST_AHALT && reset_event |=> startup_busy [*2];
    endproperty
    a_ahalt_rst: assert property (p_ahalt_rst) else $error("reset wake skipped delay"); // see R11

    property p_halt_osc;
        state_r == ST_HALT |-> !osc_enable && !periph_clk_en && !cpu_clk_en;
    endproperty
    a_halt_osc: assert property (p_halt_osc) else $error("halt not stopped"); // see R15

    property p_start_vec;
        state_r == ST_START && !dly_done |=> !irq_service && !reset_vector_fetch;
    endproperty
    a_start_vec: assert property (p_start_vec) else $error("early wake action"); // see R16

    property p_wdg_halt;
        state_r == ST_RUN && !reset_event && !wait_for_irq_instr && halt_instr &&
            !timebase_irq_enable && watchdog_enabled && watchdog_halt_option |=>
            watchdog_reset_req && state_r == ST_RUN;
    endproperty
    a_wdg_halt: assert property (p_wdg_halt) else $error("no watchdog reset"); // see R17

    property p_halt_tb;
        state_r == ST_HALT && !ext_irq && !reset_event |=> state_r == ST_HALT;
    endproperty
    a_halt_tb: assert property (p_halt_tb) else $error("halt left by timebase"); // see R18

    property p_bg_halt;
        bg_active_r && !timebase_irq_enable && state_nxt == ST_RUN |=> !osc_enable;
    endproperty
    a_bg_halt: assert property (p_bg_halt) else $error("osc kept after early clear"); // see R14

    c_slow_wait: cover property (state_r == ST_WAIT && slow_select ##1 irq_service);
    c_ahalt_wake: cover property (state_r == ST_AHALT ##1 irq_service);
    c_halt_start: cover property (state_r == ST_HALT ##1 startup_busy);
    c_wdg: cover property (watchdog_reset_req);

endmodule

// [verification/psmc_cpu_model.sv]
`timescale 1ns/10ps
module psmc_cpu_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic raise,
    input wire logic [1:0] prio_in,
    input wire logic oie_sw,
    input wire logic irq_service,
    input wire logic [2:0] power_mode,
    output logic irq_pending,
    output logic [1:0] irq_priority,
    output logic timebase_irq_enable
);
    import psmc_pkg::*;

    // ------------------------------------------------------------
    // Pending latch and timebase-enable hold
    // ------------------------------------------------------------
    logic [DLY_W-1:0] hold_r;
    logic was_ahalt_r;

    // Software keeps the enable set for one short start-up delay after an active-halt wake
    assign timebase_irq_enable = oie_sw | (hold_r != DLY_ZERO);
    assign irq_priority = prio_in;

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_pending <= 1'b0;
            hold_r <= DLY_ZERO;
            was_ahalt_r <= 1'b0;
        end else begin
            was_ahalt_r <= (power_mode == MODE_ACTIVE_HALT);
            if (raise) begin
                irq_pending <= 1'b1;
            end else if (irq_service) begin
                irq_pending <= 1'b0;
            end
            if (irq_service && was_ahalt_r) begin
                hold_r <= DLY_LOAD_SHORT;
            end else if (hold_r != DLY_ZERO) begin
                hold_r <= hold_r - 12'h001;
            end
        end
    end
endmodule

// [verification/tb.sv]
`timescale 1ns/10ps
module tb;
    import psmc_pkg::*;

    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic slow_select = 1'b0;
    logic [1:0] cpu_prescale_bits = 2'h0;
    logic oie_sw = 1'b0;
    logic wait_for_irq_instr = 1'b0;
    logic halt_instr = 1'b0;
    logic watchdog_enabled = 1'b0;
    logic watchdog_halt_option = 1'b0;
    logic long_delay_option = 1'b0;
    logic reset_event = 1'b0;
    logic irq_raise = 1'b0;
    logic [1:0] irq_prio_in = 2'h1;
    logic ext_irq = 1'b0;
    logic timebase_irq = 1'b0;
    logic css_irq = 1'b0;
    logic ccr_pop = 1'b0;
    logic [1:0] ccr_pop_level = 2'h3;
    logic timebase_irq_enable, irq_pending;
    logic [1:0] irq_priority, irq_mask_level;
    logic [2:0] power_mode;
    logic cpu_clk_en, periph_clk_en, timebase_clk_en, osc_enable, startup_busy;
    logic irq_service, stack_push_ccr, reset_vector_fetch, watchdog_reset_req;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #5 clock = ~clock;

    psmc_cpu_model model (.clock(clock), .rst(rst), .raise(irq_raise), .prio_in(irq_prio_in),
        .oie_sw(oie_sw), .irq_service(irq_service), .power_mode(power_mode),
        .irq_pending(irq_pending), .irq_priority(irq_priority),
        .timebase_irq_enable(timebase_irq_enable));

    psmc_ctrl uut (.clock(clock), .rst(rst), .clk_en(clk_en), .slow_select(slow_select),
        .cpu_prescale_bits(cpu_prescale_bits), .timebase_irq_enable(timebase_irq_enable),
        .wait_for_irq_instr(wait_for_irq_instr), .halt_instr(halt_instr),
        .watchdog_enabled(watchdog_enabled), .watchdog_halt_option(watchdog_halt_option),
        .long_delay_option(long_delay_option), .reset_event(reset_event),
        .irq_pending(irq_pending), .irq_priority(irq_priority), .ext_irq(ext_irq),
        .timebase_irq(timebase_irq), .css_irq(css_irq), .ccr_pop(ccr_pop),
        .ccr_pop_level(ccr_pop_level), .power_mode(power_mode), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .timebase_clk_en(timebase_clk_en),
        .osc_enable(osc_enable), .startup_busy(startup_busy),
        .irq_mask_level(irq_mask_level), .irq_service(irq_service),
        .stack_push_ccr(stack_push_ccr), .reset_vector_fetch(reset_vector_fetch),
        .watchdog_reset_req(watchdog_reset_req));

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_bit(logic got, logic exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_val(logic [2:0] got, logic [2:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic step(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic drive(int s, logic v);
        case (s)
            0: wait_for_irq_instr <= v;
            1: halt_instr <= v;
            2: irq_raise <= v;
            3: ext_irq <= v;
            4: timebase_irq <= v;
            5: reset_event <= v;
            6: ccr_pop <= v;
            default: css_irq <= v;
        endcase
    endtask

    // Request held one cycle; returns settled after the edge that took it
    task automatic pulse(int s);
        @(posedge clock);
        drive(s, 1'b1);
        @(posedge clock);
        drive(s, 1'b0);
        #1;
    endtask

    function automatic logic hit(int s);
        case (s)
            0: return irq_service === 1'b1;
            1: return reset_vector_fetch === 1'b1;
            default: return startup_busy === 1'b1;
        endcase
    endfunction

    task automatic wait_for(int s, int lim, output int n);
        n = 0;
        while (!hit(s) && n < lim) begin
            step(1);
            n++;
        end
        if (n >= lim) chk_bit(1'b0, 1'b1);
    endtask

    // Wake from halt or active-halt and time the start-up delay
    task automatic wake_delay(int src, int done, int dly);
        int n;
        pulse(src);
        wait_for(2, 4, n);
        chk_bit(osc_enable, 1'b1);
        wait_for(done, dly + 8, n);
        chk_bit(n >= dly - 1 && n <= dly + 1, 1'b1);
        step(2);
        chk_val(power_mode, MODE_RUN);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 12000) begin
            mismatches++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        int src[3] = '{3, 4, 7};
        step(16);
        chk_val(power_mode, MODE_RUN);
        chk_val({1'b0, irq_mask_level}, {1'b0, MASK_RESET});
        @(posedge clock);
        rst <= 1'b0;
        step(3);
        chk_bit(cpu_clk_en, 1'b1);
        pulse(0);
        chk_val(power_mode, MODE_WAIT);
        chk_bit(cpu_clk_en, 1'b0);
        chk_bit(periph_clk_en, 1'b1);
        chk_val({1'b0, irq_mask_level}, {1'b0, MASK_ALL_ENABLED});
        step(6);
        chk_val(power_mode, MODE_WAIT);
        pulse(2);
        wait_for(0, 4, n);
        chk_bit(stack_push_ccr, 1'b1);
        chk_val({1'b0, irq_mask_level}, 3'h1);
        chk_val(power_mode, MODE_RUN);
        pulse(6);
        step(1);
        chk_val({1'b0, irq_mask_level}, 3'h3);
        for (int p = 0; p < 4; p++) begin
            @(posedge clock);
            slow_select <= 1'b1;
            cpu_prescale_bits <= 2'(p);
            step(40);
            n = 0;
            repeat (64) begin
                step(1);
                n += int'(cpu_clk_en === 1'b1);
            end
            chk_bit(n == (64 >> (p + 1)), 1'b1);
            chk_val(power_mode, MODE_SLOW);
        end
        pulse(0);
        chk_val(power_mode, MODE_SLOW_WAIT);
        n = 0;
        repeat (64) begin
            step(1);
            n += int'(periph_clk_en === 1'b1);
        end
        chk_bit(n == 4, 1'b1);
        pulse(2);
        wait_for(0, 40, n);
        @(posedge clock);
        slow_select <= 1'b0;
        pulse(1);
        chk_val(power_mode, MODE_HALT);
        chk_bit(osc_enable, 1'b0);
        chk_bit(periph_clk_en, 1'b0);
        chk_bit(timebase_clk_en, 1'b0);
        chk_val({1'b0, irq_mask_level}, {1'b0, MASK_ALL_ENABLED});
        pulse(4);
        pulse(7);
        step(3);
        chk_val(power_mode, MODE_HALT);
        // Frozen block must ignore a wake source
        @(posedge clock);
        clk_en <= 1'b0;
        pulse(3);
        step(2);
        chk_val(power_mode, MODE_HALT);
        @(posedge clock);
        clk_en <= 1'b1;
        wake_delay(3, 0, STARTUP_SHORT_CYC);
        @(posedge clock);
        long_delay_option <= 1'b1;
        pulse(1);
        wake_delay(3, 0, STARTUP_LONG_CYC);
        @(posedge clock);
        long_delay_option <= 1'b0;
        oie_sw <= 1'b1;
        watchdog_enabled <= 1'b1;
        watchdog_halt_option <= 1'b1;
        foreach (src[i]) begin
            pulse(1);
            chk_val(power_mode, MODE_ACTIVE_HALT);
            chk_bit(timebase_clk_en, 1'b1);
            chk_bit(periph_clk_en, 1'b0);
            chk_bit(watchdog_reset_req, 1'b0);
            pulse(src[i]);
            wait_for(0, 2, n);
            chk_bit(n <= 1, 1'b1);
            chk_bit(startup_busy, 1'b0);
            step(2);
        end
        @(posedge clock);
        oie_sw <= 1'b0;
        step(20);
        chk_bit(osc_enable, 1'b1);
        step(300);
        pulse(1);
        chk_bit(watchdog_reset_req, 1'b1);
        chk_val(power_mode, MODE_RUN);
        @(posedge clock);
        oie_sw <= 1'b1;
        pulse(2);
        // Wake source already high at active-halt entry
        @(posedge clock);
        ext_irq <= 1'b1;
        pulse(1);
        wait_for(0, 3, n);
        chk_bit(n <= 2, 1'b1);
        @(posedge clock);
        ext_irq <= 1'b0;
        step(2);
        pulse(1);
        wake_delay(5, 1, STARTUP_SHORT_CYC);
        print_verdict();
    end
endmodule
